// ---- hdl/uae_pkg.sv ----
package uae_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [9:0] IDX_IRQ_EN    = 10'h0be;
  localparam logic [9:0] IDX_FUNC_ADDR = 10'h0c6;
  localparam logic [9:0] IDX_EP_SEL    = 10'h0c7;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h0e0;
  localparam logic [9:0] IDX_CTRL      = 10'h0e1;

  localparam int unsigned AXI_ADDR_W = 12;
  localparam int unsigned AXI_DATA_W = 32;

  // Bit positions of the enable/status sources, the filter bit of the function address and the valid bit of the control register
  localparam int unsigned BIT_WAKE    = 5;
  localparam int unsigned BIT_EOR     = 4;
  localparam int unsigned BIT_SOF     = 3;
  localparam int unsigned BIT_SUSP    = 0;
  localparam int unsigned BIT_FILTER  = 7;
  localparam int unsigned BIT_ADDR_OK = 0;

  localparam logic [7:0] IRQ_EN_MASK     = 8'h39;
  localparam logic [7:0] EP_SEL_MASK     = 8'h0f;
  localparam logic [7:0] IRQ_EN_RESET    = 8'h10;
  localparam logic [7:0] FUNC_ADDR_RESET = 8'h00;
  localparam logic [7:0] EP_SEL_RESET    = 8'h00;
  localparam logic [7:0] IRQ_STAT_RESET  = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Bus reset detection: three full-speed bit times, rounded up to clocks
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned FS_BIT_HZ     = 12_000_000;
  localparam int unsigned SE0_MIN_BITS  = 3;
  localparam int unsigned SE0_CYCLES    = (SE0_MIN_BITS * CLK_HZ + FS_BIT_HZ - 1) / FS_BIT_HZ;
  localparam int unsigned SE0_CNT_W     = 6;

  typedef enum logic [2:0] {
    REG_NONE      = 3'b000,
    REG_IRQ_EN    = 3'b001,
    REG_FUNC_ADDR = 3'b010,
    REG_EP_SEL    = 3'b011,
    REG_IRQ_STAT  = 3'b100,
    REG_CTRL      = 3'b101
  } uae_reg_e;

  typedef struct packed {
    logic wake;
    logic sof;
    logic suspend;
  } uae_event_s;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } uae_token_s;

endpackage : uae_pkg

// ---- hdl/uae_se0_det.sv ----
`timescale 1ns/1ps
module uae_se0_det (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_se0,
  output logic      o_bus_reset,
  output logic      o_reset_end
);

  typedef struct packed {
    logic                             sync1;
    logic                             sync2;
    logic [uae_pkg::SE0_CNT_W-1:0]    cnt;
    logic                             bus_reset;
    logic                             reset_end;
  } uae_det_s;

  localparam logic [uae_pkg::SE0_CNT_W-1:0] CNT_MAX = uae_pkg::SE0_CNT_W'(uae_pkg::SE0_CYCLES);

  uae_det_s r;
  uae_det_s next_r;

  always_comb begin
    next_r = r;
    next_r.sync1 = i_se0;
    next_r.sync2 = r.sync1;
    if (!r.sync2) begin
      next_r.cnt = '0;
    end else if (r.cnt != CNT_MAX) begin
      next_r.cnt = r.cnt + 1'b1;
    end
    next_r.bus_reset = (next_r.cnt == CNT_MAX);
    next_r.reset_end = r.bus_reset && !next_r.bus_reset;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else if (i_ce) begin
      r <= next_r;
    end
  end

  assign o_bus_reset = r.bus_reset;
  assign o_reset_end = r.reset_end;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn || !i_ce);

  se0_long_a: assert property ($rose(r.bus_reset) |-> $past(r.cnt) == CNT_MAX - 1'b1)
    else $error("bus reset raised before the SE0 time");
  se0_drop_a: assert property (!r.sync2 |=> !r.bus_reset && r.cnt == '0)
    else $error("bus reset held after SE0 ended");
  reset_end_c: cover property (r.reset_end);

endmodule : uae_se0_det

// ---- hdl/uae_regs.sv ----
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module uae_regs (
  input  wire logic                                I_SYS_CLK,
  input  wire logic                                I_RESETN,
  input  wire logic                                I_CE,
  input  wire logic [uae_pkg::AXI_ADDR_W-1:0]      I_AWADDR,
  input  wire logic                                I_AWVALID,
  output logic                                     O_AWREADY,
  input  wire logic [uae_pkg::AXI_DATA_W-1:0]      I_WDATA,
  input  wire logic [3:0]                          I_WSTRB,
  input  wire logic                                I_WVALID,
  output logic                                     O_WREADY,
  output logic [1:0]                               O_BRESP,
  output logic                                     O_BVALID,
  input  wire logic                                I_BREADY,
  input  wire logic [uae_pkg::AXI_ADDR_W-1:0]      I_ARADDR,
  input  wire logic                                I_ARVALID,
  output logic                                     O_ARREADY,
  output logic [uae_pkg::AXI_DATA_W-1:0]           O_RDATA,
  output logic [1:0]                               O_RRESP,
  output logic                                     O_RVALID,
  input  wire logic                                I_RREADY,
  input  wire logic                                I_SE0,
  input  wire uae_pkg::uae_event_s                 I_EVENT,
  input  wire uae_pkg::uae_token_s                 I_TOKEN,
  output logic                                     O_TOKEN_ACCEPT,
  output logic [6:0]                               O_ACTIVE_ADDR,
  output logic                                     O_ADDR_FILTER_EN,
  output logic [3:0]                               O_EP_SEL,
  output logic                                     O_BUS_RESET,
  output logic                                     O_IRQ
);

  typedef struct packed {
    logic       aw_full;
    logic [9:0] aw_idx;
    logic       w_full;
    logic [7:0] w_data;
    logic       w_lane0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [7:0] irq_en;
    logic [7:0] func_addr;
    logic [7:0] ep_sel;
    logic [7:0] irq_stat;
    logic       addr_valid;
    logic       irq;
    logic       token_accept;
    logic [6:0] active_addr;
  } uae_state_s;

  uae_state_s r;
  uae_state_s next_r;
  logic       bus_reset;
  logic       reset_end;

  function automatic uae_pkg::uae_reg_e reg_of(input logic [9:0] idx);
    case (idx)
      uae_pkg::IDX_IRQ_EN:    reg_of = uae_pkg::REG_IRQ_EN;
      uae_pkg::IDX_FUNC_ADDR: reg_of = uae_pkg::REG_FUNC_ADDR;
      uae_pkg::IDX_EP_SEL:    reg_of = uae_pkg::REG_EP_SEL;
      uae_pkg::IDX_IRQ_STAT:  reg_of = uae_pkg::REG_IRQ_STAT;
      uae_pkg::IDX_CTRL:      reg_of = uae_pkg::REG_CTRL;
      default:                reg_of = uae_pkg::REG_NONE;
    endcase
  endfunction : reg_of

  uae_se0_det u_se0_det (
    .i_clk       (I_SYS_CLK),
    .i_resetn    (I_RESETN),
    .i_ce        (I_CE),
    .i_se0       (I_SE0),
    .o_bus_reset (bus_reset),
    .o_reset_end (reset_end)
  );

  always_comb begin
    logic [7:0]        ev_set;
    logic [7:0]        stat_clr;
    uae_pkg::uae_reg_e wr_reg;
    uae_pkg::uae_reg_e rd_reg;
    ev_set   = '0;
    stat_clr = '0;
    wr_reg   = reg_of(r.aw_idx);
    rd_reg   = reg_of(I_ARADDR[11:2]);
    next_r   = r;

    // Address and data are taken independently, in either order
    if (r.awready && I_AWVALID) begin
      next_r.aw_full = 1'b1;
      next_r.aw_idx  = I_AWADDR[11:2];
    end
    if (r.wready && I_WVALID) begin
      next_r.w_full  = 1'b1;
      next_r.w_data  = I_WDATA[7:0];
      next_r.w_lane0 = I_WSTRB[0];
    end
    if (r.bvalid && I_BREADY) begin
      next_r.bvalid = 1'b0;
    end

    if (r.aw_full && r.w_full && !r.bvalid) begin
      next_r.aw_full = 1'b0;
      next_r.w_full  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = (wr_reg == uae_pkg::REG_NONE) ? uae_pkg::RESP_SLVERR : uae_pkg::RESP_OKAY;
      if (r.w_lane0) begin
        case (wr_reg)
          uae_pkg::REG_IRQ_EN: begin
            next_r.irq_en = r.w_data & uae_pkg::IRQ_EN_MASK;
          end
          uae_pkg::REG_FUNC_ADDR: begin
            next_r.func_addr = r.w_data;
          end
          uae_pkg::REG_EP_SEL: begin
            next_r.ep_sel = r.w_data & uae_pkg::EP_SEL_MASK;
          end
          uae_pkg::REG_IRQ_STAT: begin
            stat_clr = r.w_data & uae_pkg::IRQ_EN_MASK;
          end
          uae_pkg::REG_CTRL: begin
            next_r.addr_valid = r.w_data[uae_pkg::BIT_ADDR_OK];
          end
          default: begin
            next_r.bresp = uae_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    next_r.awready = !next_r.aw_full && !next_r.bvalid;
    next_r.wready  = !next_r.w_full && !next_r.bvalid;

    if (r.rvalid && I_RREADY) begin
      next_r.rvalid  = 1'b0;
      next_r.arready = 1'b1;
    end
    if (r.arready && I_ARVALID) begin
      next_r.arready = 1'b0;
      next_r.rvalid  = 1'b1;
      next_r.rresp   = uae_pkg::RESP_OKAY;
      case (rd_reg)
        uae_pkg::REG_IRQ_EN:    next_r.rdata = r.irq_en & uae_pkg::IRQ_EN_MASK;
        uae_pkg::REG_FUNC_ADDR: next_r.rdata = r.func_addr;
        uae_pkg::REG_EP_SEL:    next_r.rdata = r.ep_sel & uae_pkg::EP_SEL_MASK;
        uae_pkg::REG_IRQ_STAT:  next_r.rdata = r.irq_stat;
        uae_pkg::REG_CTRL:      next_r.rdata = {7'h00, r.addr_valid};
        default: begin
          next_r.rdata = 8'h00;
          next_r.rresp = uae_pkg::RESP_SLVERR;
        end
      endcase
    end

    // A bus reset clears address bits 6:0 and addr_valid, overriding a firmware write in the same cycle
    if (bus_reset) begin
      next_r.func_addr[6:0] = 7'h00;
      next_r.addr_valid     = 1'b0;
    end

    // Events win over a write-one clear in the same cycle
    ev_set[uae_pkg::BIT_WAKE] = I_EVENT.wake;
    ev_set[uae_pkg::BIT_EOR]  = reset_end;
    ev_set[uae_pkg::BIT_SOF]  = I_EVENT.sof;
    ev_set[uae_pkg::BIT_SUSP] = I_EVENT.suspend;
    next_r.irq_stat = (r.irq_stat & ~stat_clr) | ev_set;
    next_r.irq = |(next_r.irq_stat & next_r.irq_en);

    next_r.active_addr = next_r.addr_valid ? next_r.func_addr[6:0] : 7'h00;
    next_r.token_accept = I_TOKEN.valid &&
                          (!r.func_addr[uae_pkg::BIT_FILTER] ||
                           I_TOKEN.addr == r.active_addr);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      r           <= '0;
      r.awready   <= 1'b1;
      r.wready    <= 1'b1;
      r.arready   <= 1'b1;
      r.irq_en    <= uae_pkg::IRQ_EN_RESET;
      r.func_addr <= uae_pkg::FUNC_ADDR_RESET;
      r.ep_sel    <= uae_pkg::EP_SEL_RESET;
      r.irq_stat  <= uae_pkg::IRQ_STAT_RESET;
    end else if (I_CE) begin
      r <= next_r;
    end
  end

  assign O_AWREADY        = r.awready;
  assign O_WREADY         = r.wready;
  assign O_BVALID         = r.bvalid;
  assign O_BRESP          = r.bresp;
  assign O_ARREADY        = r.arready;
  assign O_RVALID         = r.rvalid;
  assign O_RRESP          = r.rresp;
  assign O_RDATA          = {24'h000000, r.rdata};
  assign O_TOKEN_ACCEPT   = r.token_accept;
  assign O_ACTIVE_ADDR    = r.active_addr;
  assign O_ADDR_FILTER_EN = r.func_addr[uae_pkg::BIT_FILTER];
  assign O_EP_SEL         = r.ep_sel[3:0];
  assign O_BUS_RESET      = bus_reset;
  assign O_IRQ            = r.irq;

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN || !I_CE);

  rsvd_zero_a: assert property ((r.irq_en & ~uae_pkg::IRQ_EN_MASK) == 8'h00 &&
                                r.ep_sel[7:4] == 4'h0)
    else $error("reserved bits hold a one");
  wake_gate_a: assert property (I_EVENT.wake |=> O_IRQ || !r.irq_en[uae_pkg::BIT_WAKE])
    else $error("wake-up event did not raise the interrupt");
  eor_reset_a: assert property (@(posedge I_SYS_CLK) disable iff (1'b0)
                                $rose(I_RESETN) |-> r.irq_en == uae_pkg::IRQ_EN_RESET)
    else $error("enable register not 10h after reset");
  eor_gate_a: assert property (reset_end |=> O_IRQ || !r.irq_en[uae_pkg::BIT_EOR])
    else $error("end of bus reset did not raise the interrupt");
  sof_gate_a: assert property (I_EVENT.sof |=> r.irq_stat[uae_pkg::BIT_SOF] &&
                               (O_IRQ || !r.irq_en[uae_pkg::BIT_SOF]))
    else $error("start-of-frame event did not raise the interrupt");
  susp_gate_a: assert property (I_EVENT.suspend ##1 r.irq_en[uae_pkg::BIT_SUSP] |-> O_IRQ)
    else $error("suspend event did not raise the interrupt");
  no_filter_a: assert property (I_TOKEN.valid && !O_ADDR_FILTER_EN |=> O_TOKEN_ACCEPT)
    else $error("token refused with filtering off");
  addr_clear_a: assert property (bus_reset |=> r.func_addr[6:0] == 7'h00 && !r.addr_valid)
    else $error("function address kept through bus reset");
  ep_sel_a: assert property (r.aw_full && r.w_full && !r.bvalid && r.w_lane0 &&
                             r.aw_idx == uae_pkg::IDX_EP_SEL
                             |=> O_EP_SEL == $past(r.w_data[3:0]))
    else $error("endpoint selector did not follow the write");
  default_addr_a: assert property (!r.addr_valid |-> O_ACTIVE_ADDR == 7'h00)
    else $error("active address not zero while address invalid");
  match_only_a: assert property (I_TOKEN.valid && O_ADDR_FILTER_EN &&
                                 I_TOKEN.addr != O_ACTIVE_ADDR |=> !O_TOKEN_ACCEPT)
    else $error("token with foreign address accepted");

  // Register bus contract
  aw_take_a: assert property (r.awready && I_AWVALID
                              |=> r.aw_full && !r.awready)
    else $error("write address not held after it was taken");
  w_take_a: assert property (r.wready && I_WVALID
                             |=> r.w_full && !r.wready)
    else $error("write data not held after it was taken");
  b_answer_a: assert property (r.aw_full && r.w_full
                               |=> r.bvalid && !r.aw_full && !r.w_full)
    else $error("write response not raised one cycle after address and data");
  b_hold_a: assert property (r.bvalid && !I_BREADY
                             |=> r.bvalid && $stable(r.bresp))
    else $error("write response dropped before it was taken");
  b_done_a: assert property (r.bvalid && I_BREADY
                             |=> !r.bvalid && r.awready && r.wready)
    else $error("write channels not ready after the response");
  aw_block_a: assert property (r.bvalid
                               |-> !r.awready && !r.wready)
    else $error("write channel ready while a response is pending");
  wr_err_a: assert property (r.aw_full && r.w_full && reg_of(r.aw_idx) == uae_pkg::REG_NONE
                             |=> O_BRESP == uae_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  wr_ok_a: assert property (r.aw_full && r.w_full && reg_of(r.aw_idx) != uae_pkg::REG_NONE
                            |=> O_BRESP == uae_pkg::RESP_OKAY)
    else $error("mapped write refused");
  strobe_skip_a: assert property (r.aw_full && r.w_full && !r.w_lane0
                                  |=> $stable(r.irq_en) && $stable(r.ep_sel))
    else $error("write without byte strobe changed a register");
  r_answer_a: assert property (r.arready && I_ARVALID
                               |=> r.rvalid && !r.arready)
    else $error("read data not raised one cycle after the address");
  r_hold_a: assert property (r.rvalid && !I_RREADY
                             |=> r.rvalid && $stable(r.rdata) && $stable(r.rresp))
    else $error("read data changed before it was taken");
  r_done_a: assert property (r.rvalid && I_RREADY
                             |=> !r.rvalid && r.arready)
    else $error("read address channel not ready after the data");
  ar_block_a: assert property (r.rvalid
                               |-> !r.arready)
    else $error("read address ready while data is pending");
  rd_err_a: assert property (r.arready && I_ARVALID && reg_of(I_ARADDR[11:2]) == uae_pkg::REG_NONE
                             |=> O_RRESP == uae_pkg::RESP_SLVERR && O_RDATA == 32'h00000000)
    else $error("unmapped read not refused");

  // Status, address and selector
  wake_set_a: assert property (I_EVENT.wake
                               |=> r.irq_stat[uae_pkg::BIT_WAKE])
    else $error("wake-up event not latched");
  eor_set_a: assert property (reset_end
                              |=> r.irq_stat[uae_pkg::BIT_EOR])
    else $error("end of bus reset not latched");
  susp_set_a: assert property (I_EVENT.suspend
                               |=> r.irq_stat[uae_pkg::BIT_SUSP])
    else $error("suspend event not latched");
  wake_clear_a: assert property (r.aw_full && r.w_full && r.w_lane0 &&
                                 r.aw_idx == uae_pkg::IDX_IRQ_STAT &&
                                 r.w_data[uae_pkg::BIT_WAKE] && !I_EVENT.wake
                                 |=> !r.irq_stat[uae_pkg::BIT_WAKE])
    else $error("wake-up status not cleared by a written one");
  active_addr_a: assert property (r.addr_valid
                                  |-> O_ACTIVE_ADDR == r.func_addr[6:0])
    else $error("active address differs from the function address");
  token_pulse_a: assert property (!I_TOKEN.valid
                                  |=> !O_TOKEN_ACCEPT)
    else $error("token accepted with no token offered");
  ep_hold_a: assert property (!(r.aw_full && r.w_full && r.w_lane0 &&
                                r.aw_idx == uae_pkg::IDX_EP_SEL)
                              |=> $stable(O_EP_SEL))
    else $error("endpoint selector changed without a write");
  addr_hold_a: assert property (!bus_reset && !(r.aw_full && r.w_full && r.w_lane0 &&
                                                r.aw_idx == uae_pkg::IDX_FUNC_ADDR)
                                |=> $stable(r.func_addr))
    else $error("function address changed without a write or bus reset");

  irq_raise_c: cover property ($rose(O_IRQ));
  ep_write_c: cover property (r.bvalid && r.aw_idx == uae_pkg::IDX_EP_SEL);
  token_ok_c: cover property (O_TOKEN_ACCEPT && O_ADDR_FILTER_EN);
  read_err_c: cover property (r.rvalid && r.rresp == uae_pkg::RESP_SLVERR);

endmodule : uae_regs

// ---- verification/uae_regs_tb.sv ----
`timescale 1ns/1ps
module uae_regs_tb;
  localparam logic [1:0] OK  = uae_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = uae_pkg::RESP_SLVERR;

  logic                clk = 1'b0;
  logic                rstn = 1'b0;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                arvalid = 1'b0, rready = 1'b0, se0 = 1'b0;
  logic [11:0]         awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]         wdata = 32'h0, rdata;
  logic [1:0]          bresp, rresp, resp;
  logic                awready, wready, bvalid, arready, rvalid;
  logic                acc, irq, bus_rst, filt;
  logic [6:0]          act, a7;
  logic [3:0]          ep;
  logic [7:0]          v;
  uae_pkg::uae_event_s ev = '0;
  uae_pkg::uae_token_s tk = '0;
  int                  failures = 0, num_checks = 0;

  always #2.5 clk = ~clk;

  uae_regs u_dut (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_CE(1'b1),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(4'h1), .I_WVALID(wvalid), .O_WREADY(wready),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
    .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_SE0(se0), .I_EVENT(ev), .I_TOKEN(tk), .O_TOKEN_ACCEPT(acc),
    .O_ACTIVE_ADDR(act), .O_ADDR_FILTER_EN(filt), .O_EP_SEL(ep),
    .O_BUS_RESET(bus_rst), .O_IRQ(irq));

  function automatic logic exp_irq(input logic [7:0] en, input logic [7:0] st);
    return |(en & st & uae_pkg::IRQ_EN_MASK);
  endfunction : exp_irq

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    resp = 2'bxx;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No time limit here: only the watchdog ends a wait for a response that never comes
    while (!done) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    check(resp, er);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic [31:0] got;
    logic        done;
    got = 'x;
    done = 1'b0;
    resp = 2'bxx;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    check(got, {24'h0, exp});
    check(resp, er);
  endtask : rd

  task automatic pulse(input uae_pkg::uae_event_s e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic tok(input logic [6:0] ad, input logic ex);
    @(posedge clk);
    tk <= '{valid: 1'b1, addr: ad};
    @(posedge clk);
    tk <= '0;
    @(posedge clk);
    check(acc, ex);
  endtask : tok

  initial begin
    repeat (6000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h0664));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(uae_pkg::IDX_IRQ_EN, 8'h10, OK);
    rd(uae_pkg::IDX_FUNC_ADDR, 8'h00, OK);
    wr(uae_pkg::IDX_IRQ_EN, 8'hff, OK);
    rd(uae_pkg::IDX_IRQ_EN, 8'h39, OK);
    wr(uae_pkg::IDX_EP_SEL, 8'hff, OK);
    rd(uae_pkg::IDX_EP_SEL, 8'h0f, OK);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom_range(6, 0));
      wr(uae_pkg::IDX_EP_SEL, v, OK);
      rd(uae_pkg::IDX_EP_SEL, v, OK);
      check(ep, v[3:0]);
    end
    wr(10'h001, 8'h55, ERR);
    rd(10'h001, 8'h00, ERR);
    // Wake, SOF and suspend pending while every enable is off
    wr(uae_pkg::IDX_IRQ_EN, 8'h00, OK);
    pulse(3'b111);
    check(irq, 1'b0);
    rd(uae_pkg::IDX_IRQ_STAT, 8'h29, OK);
    for (int b = 0; b < 6; b++) begin
      wr(uae_pkg::IDX_IRQ_EN, 8'h01 << b, OK);
      check(irq, exp_irq(8'h01 << b, 8'h29));
    end
    wr(uae_pkg::IDX_IRQ_STAT, 8'h29, OK);
    check(irq, 1'b0);
    rd(uae_pkg::IDX_IRQ_STAT, 8'h00, OK);
    a7 = 7'($urandom_range(127, 1));
    wr(uae_pkg::IDX_FUNC_ADDR, {1'b1, a7}, OK);
    check(act, 7'h00);
    wr(uae_pkg::IDX_CTRL, 8'h01, OK);
    check(act, a7);
    check(filt, 1'b1);
    tok(a7, 1'b1);
    tok(a7 ^ 7'h01, 1'b0);
    wr(uae_pkg::IDX_FUNC_ADDR, {1'b0, a7}, OK);
    tok(a7 ^ 7'h01, 1'b1);
    wr(uae_pkg::IDX_FUNC_ADDR, {1'b1, a7}, OK);
    wr(uae_pkg::IDX_IRQ_EN, 8'h10, OK);
    @(posedge clk);
    se0 <= 1'b1;
    repeat (uae_pkg::SE0_CYCLES - 10) @(posedge clk);
    check(bus_rst, 1'b0);
    repeat (20) @(posedge clk);
    check(bus_rst, 1'b1);
    check(act, 7'h00);
    // Address bits 6:0 written while the bus reset lasts must be lost; the filter bit stays
    wr(uae_pkg::IDX_FUNC_ADDR, 8'h85, OK);
    @(posedge clk);
    se0 <= 1'b0;
    repeat (10) @(posedge clk);
    check(bus_rst, 1'b0);
    rd(uae_pkg::IDX_FUNC_ADDR, 8'h80, OK);
    rd(uae_pkg::IDX_CTRL, 8'h00, OK);
    rd(uae_pkg::IDX_IRQ_STAT, 8'h10, OK);
    check(irq, 1'b1);
    wr(uae_pkg::IDX_IRQ_EN, 8'h00, OK);
    check(irq, 1'b0);
    complete_run();
  end
endmodule : uae_regs_tb
